// ===== rtl/mie_pkg.sv
// Package of opcodes, flag layout and constants for the execute unit.
`default_nettype none
package mie_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int         DATA_W      = 8;
  localparam int         ADDR_W      = 8;
  localparam int         PC_W        = 11;
  localparam int         STACK_DEPTH = 8;
  localparam logic [7:0] W_RST       = 8'h00;
  localparam logic [10:0] PC_RST     = 11'h000;
  localparam logic [3:0] FLAGS_RST   = 4'h0;

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_IDLE, OP_SLEEP, OP_WATCHDOG_KICK,
    OP_STORE_W, OP_MOVE, OP_ZERO_PROBE, OP_LOAD_IMMEDIATE,
    OP_CLEAR_W, OP_SET_ALL, OP_CLEAR_REG,
    OP_OR, OP_AND, OP_XOR, OP_OR_IMM, OP_AND_IMM, OP_XOR_IMM,
    OP_NIBBLE_EXCHANGE, OP_INVERT,
    OP_ROT_RIGHT_CARRY, OP_ROT_LEFT_CARRY, OP_ROT_LEFT, OP_ROT_RIGHT,
    OP_INCREMENT, OP_DECREMENT, OP_BIT_ZERO, OP_BIT_ONE,
    OP_LOOKUP_W, OP_LOOKUP_REG,
    OP_SUM, OP_SUM_CARRY, OP_SUM_IMM,
    OP_FWD_DIFF, OP_FWD_DIFF_BORROW, OP_IMM_MINUS_W,
    OP_REV_DIFF, OP_REV_DIFF_BORROW, OP_W_MINUS_IMM,
    OP_SUBROUTINE_EXIT, OP_EXIT_LOAD_W, OP_INTERRUPT_EXIT,
    OP_CALL, OP_GOTO,
    OP_SKIP_BIT_ZERO, OP_SKIP_BIT_ONE,
    OP_MOVE_SKIP_ZERO, OP_MOVE_SKIP_NONZERO,
    OP_INC_SKIP_ZERO, OP_DEC_SKIP_ZERO
  } mie_op_t;

  // ----------------------------------------------------------------
  // Decoded instruction and status flags
  // ----------------------------------------------------------------
  typedef struct packed {
    mie_op_t     op;
    logic        to_reg;
    logic [7:0]  addr;
    logic [7:0]  imm;
    logic [2:0]  bit_sel;
    logic [10:0] target;
  } mie_instr_t;

  typedef struct packed {
    logic carry;
    logic half_carry;
    logic zero;
    logic overflow;
  } mie_flags_t;

  typedef struct packed {
    logic [7:0] value;
    mie_flags_t flags;
  } mie_alu_t;

endpackage : mie_pkg
`default_nettype wire

// ===== rtl/mie_adder.sv
// Eight-bit adder with carry, half-carry and overflow outputs.
`default_nettype none
module mie_adder (
  // Operands
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic       i_cin,
  // Result
  output logic      [7:0] o_sum,
  output logic            o_carry,
  output logic            o_half_carry,
  output logic            o_overflow
);

  logic [8:0] full;
  logic [4:0] low;

  assign full         = {1'b0, i_a} + {1'b0, i_b} + {8'h00, i_cin};
  assign low          = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, i_cin};
  assign o_sum        = full[7:0];
  assign o_carry      = full[8];
  assign o_half_carry = low[4];
  // Overflow when both inputs share a sign that the result lacks.
  assign o_overflow   = (i_a[7] == i_b[7]) && (full[7] != i_a[7]);

endmodule : mie_adder
`default_nettype wire

// ===== rtl/mie_core.sv
// Instruction execute unit of an eight-bit microcontroller core.
//
// Contract
// - Store work_register to memory in one cycle, flags unchanged.
// - Load work_register from memory in one cycle, update zero flag.
// - Zero probe writes location back to itself, updates zero flag.
// - OR/AND/XOR of memory and W to W or memory, zero updated.
// - OR/AND/XOR of immediate and W into W, zero updated.
// - Nibble exchange of memory operand to W or memory, no flags.
// - Complement of memory operand to W or memory, zero updated.
// - Right rotate through carry: carry to bit 7, bit 0 to carry.
// - Left rotate through carry: carry to bit 0, bit 7 to carry.
// - Plain left rotate, bit 7 to bit 0, no flags.
// - Plain right rotate, bit 0 to bit 7, no flags.
// - Increment or decrement modulo 256, only zero flag updated.
// - Clear or set one selected bit, other bits and flags kept.
// - Table lookup takes two cycles; high byte to lookup_high_byte.
// - Addition with optional carry updates C, half-carry, Z, OV.
// - Forward subtraction operand minus W updates all four flags.
// - Subtraction with borrow also subtracts the current carry.
// - Calls, jumps and returns take two cycles, no flags changed.
// - Bit-test skip takes two cycles when skipping, otherwise one.
// - Move-and-skip copies to W, skips on zero or nonzero.
// - Increment/decrement skip writes result, skips on zero, no flags.
// - Sleep takes one cycle, sets timeout flag, clears powerdown flag, halts.
`default_nettype none
module mie_core (
  // Clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  // Decoded instruction
  input  wire logic                 i_valid,
  input  wire mie_pkg::mie_instr_t  i_instr,
  // Data memory and program flash read data
  input  wire logic [7:0]           i_mem_rdata,
  input  wire logic [15:0]          i_flash_rdata,
  // Wake from sleep
  input  wire logic                 i_wake,
  // Instruction accept and retire
  output logic                      o_ready,
  output logic                      o_retire,
  output logic                      o_skip,
  // Data memory write
  output logic                      o_mem_we,
  output logic [7:0]                o_mem_addr,
  output logic [7:0]                o_mem_wdata,
  // Flash lookup request
  output logic                      o_flash_re,
  // Architectural state
  output logic [7:0]                o_work_register,
  output logic [7:0]                o_lookup_high_byte,
  output mie_pkg::mie_flags_t       o_flags,
  output logic                      o_timeout_flag,
  output logic                      o_powerdown_flag,
  output logic [10:0]               o_pc,
  output logic                      o_asleep
);

  // ----------------------------------------------------------------
  // Internal state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_EXEC, ST_SECOND, ST_SLEEP} mie_state_t;

  mie_state_t           state;
  mie_pkg::mie_instr_t  held;
  logic [10:0]          stack [mie_pkg::STACK_DEPTH];
  logic [2:0]           sp;
  logic [10:0]          isr_return;
  logic                 take;
  logic [7:0]           w;
  mie_pkg::mie_flags_t  flg;

  // Adder operand selection.
  logic [7:0]           add_a;
  logic [7:0]           add_b;
  logic                 add_cin;
  logic                 is_sub;
  logic [7:0]           add_sum;
  logic                 add_c;
  logic                 add_h;
  logic                 add_v;

  // Combinational result.
  logic [7:0]           next_value;
  mie_pkg::mie_flags_t  next_flags;
  logic                 next_write_w;
  logic                 next_write_mem;
  logic                 next_skip;
  logic                 next_two;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction : bit_mask

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction : is_zero

  assign take = (state == ST_EXEC) && i_valid;
  assign w    = o_work_register;
  assign flg  = o_flags;

  // ----------------------------------------------------------------
  // Adder operands
  // ----------------------------------------------------------------
  // Subtraction adds the inverted subtrahend plus one, so carry set
  // means no borrow; borrow forms subtract the carry flag itself.
  always_comb begin
    add_a   = i_mem_rdata;
    add_b   = w;
    add_cin = 1'b0;
    is_sub  = 1'b0;
    case (i_instr.op)
      mie_pkg::OP_SUM_CARRY: begin
        add_cin = flg.carry;
      end
      mie_pkg::OP_SUM_IMM: begin
        add_a = i_instr.imm;
      end
      mie_pkg::OP_FWD_DIFF: begin
        is_sub = 1'b1;
      end
      mie_pkg::OP_FWD_DIFF_BORROW: begin
        is_sub = 1'b1;
      end
      mie_pkg::OP_IMM_MINUS_W: begin
        add_a  = i_instr.imm;
        is_sub = 1'b1;
      end
      mie_pkg::OP_REV_DIFF, mie_pkg::OP_REV_DIFF_BORROW: begin
        add_a  = w;
        add_b  = i_mem_rdata;
        is_sub = 1'b1;
      end
      mie_pkg::OP_W_MINUS_IMM: begin
        add_a  = w;
        add_b  = i_instr.imm;
        is_sub = 1'b1;
      end
      default: begin
        add_cin = 1'b0;
      end
    endcase
    if (is_sub) begin
      add_b   = ~add_b;
      add_cin = 1'b1;
      if (i_instr.op == mie_pkg::OP_FWD_DIFF_BORROW ||
          i_instr.op == mie_pkg::OP_REV_DIFF_BORROW) begin
        add_cin = !flg.carry;
      end
    end
  end

  mie_adder u_adder (
    .i_a          (add_a),
    .i_b          (add_b),
    .i_cin        (add_cin),
    .o_sum        (add_sum),
    .o_carry      (add_c),
    .o_half_carry (add_h),
    .o_overflow   (add_v)
  );

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] r;
    r              = i_mem_rdata;
    next_value     = r;
    next_flags     = flg;
    next_write_w   = 1'b0;
    next_write_mem = 1'b0;
    next_skip      = 1'b0;
    next_two       = 1'b0;
    case (i_instr.op)
      mie_pkg::OP_STORE_W: begin
        next_value     = w;
        next_write_mem = 1'b1;
      end
      mie_pkg::OP_MOVE: begin
        next_write_w    = 1'b1;
        next_flags.zero = is_zero(r);
      end
      mie_pkg::OP_ZERO_PROBE: begin
        next_write_mem  = 1'b1;
        next_flags.zero = is_zero(r);
      end
      mie_pkg::OP_LOAD_IMMEDIATE: begin
        next_value   = i_instr.imm;
        next_write_w = 1'b1;
      end
      mie_pkg::OP_CLEAR_W: begin
        next_value      = 8'h00;
        next_write_w    = 1'b1;
        next_flags.zero = 1'b1;
      end
      mie_pkg::OP_SET_ALL: begin
        next_value     = 8'hFF;
        next_write_mem = 1'b1;
      end
      mie_pkg::OP_CLEAR_REG: begin
        next_value      = 8'h00;
        next_write_mem  = 1'b1;
        next_flags.zero = 1'b1;
      end
      mie_pkg::OP_OR, mie_pkg::OP_AND, mie_pkg::OP_XOR: begin
        next_value = (i_instr.op == mie_pkg::OP_OR)  ? (r | w) :
                     (i_instr.op == mie_pkg::OP_AND) ? (r & w) : (r ^ w);
        next_write_w    = !i_instr.to_reg;
        next_write_mem  = i_instr.to_reg;
        next_flags.zero = is_zero(next_value);
      end
      mie_pkg::OP_OR_IMM, mie_pkg::OP_AND_IMM, mie_pkg::OP_XOR_IMM: begin
        next_value = (i_instr.op == mie_pkg::OP_OR_IMM)  ? (i_instr.imm | w) :
                     (i_instr.op == mie_pkg::OP_AND_IMM) ? (i_instr.imm & w) :
                                                          (i_instr.imm ^ w);
        next_write_w    = 1'b1;
        next_flags.zero = is_zero(next_value);
      end
      mie_pkg::OP_NIBBLE_EXCHANGE: begin
        next_value     = {r[3:0], r[7:4]};
        next_write_w   = !i_instr.to_reg;
        next_write_mem = i_instr.to_reg;
      end
      mie_pkg::OP_INVERT: begin
        next_value      = ~r;
        next_write_w    = !i_instr.to_reg;
        next_write_mem  = i_instr.to_reg;
        next_flags.zero = is_zero(~r);
      end
      mie_pkg::OP_ROT_RIGHT_CARRY: begin
        next_value       = {flg.carry, r[7:1]};
        next_flags.carry = r[0];
        next_write_w     = !i_instr.to_reg;
        next_write_mem   = i_instr.to_reg;
      end
      mie_pkg::OP_ROT_LEFT_CARRY: begin
        next_value       = {r[6:0], flg.carry};
        next_flags.carry = r[7];
        next_write_w     = !i_instr.to_reg;
        next_write_mem   = i_instr.to_reg;
      end
      mie_pkg::OP_ROT_LEFT: begin
        next_value     = {r[6:0], r[7]};
        next_write_w   = !i_instr.to_reg;
        next_write_mem = i_instr.to_reg;
      end
      mie_pkg::OP_ROT_RIGHT: begin
        next_value     = {r[0], r[7:1]};
        next_write_w   = !i_instr.to_reg;
        next_write_mem = i_instr.to_reg;
      end
      mie_pkg::OP_INCREMENT, mie_pkg::OP_DECREMENT: begin
        next_value = (i_instr.op == mie_pkg::OP_INCREMENT) ? r + 8'h01
                                                          : r - 8'h01;
        next_write_w    = !i_instr.to_reg;
        next_write_mem  = i_instr.to_reg;
        next_flags.zero = is_zero(next_value);
      end
      mie_pkg::OP_BIT_ZERO: begin
        next_value     = r & ~bit_mask(i_instr.bit_sel);
        next_write_mem = 1'b1;
      end
      mie_pkg::OP_BIT_ONE: begin
        next_value     = r | bit_mask(i_instr.bit_sel);
        next_write_mem = 1'b1;
      end
      mie_pkg::OP_LOOKUP_W, mie_pkg::OP_LOOKUP_REG: begin
        next_two = 1'b1;
      end
      mie_pkg::OP_SUM, mie_pkg::OP_SUM_CARRY, mie_pkg::OP_SUM_IMM,
      mie_pkg::OP_FWD_DIFF, mie_pkg::OP_FWD_DIFF_BORROW,
      mie_pkg::OP_IMM_MINUS_W,
      mie_pkg::OP_REV_DIFF, mie_pkg::OP_REV_DIFF_BORROW,
      mie_pkg::OP_W_MINUS_IMM: begin
        next_value   = add_sum;
        next_flags   = '{carry: add_c, half_carry: add_h,
                         zero: is_zero(add_sum), overflow: add_v};
        next_write_w = !i_instr.to_reg ||
                       i_instr.op == mie_pkg::OP_SUM_IMM ||
                       i_instr.op == mie_pkg::OP_IMM_MINUS_W ||
                       i_instr.op == mie_pkg::OP_W_MINUS_IMM;
        next_write_mem = !next_write_w;
      end
      mie_pkg::OP_SUBROUTINE_EXIT, mie_pkg::OP_INTERRUPT_EXIT,
      mie_pkg::OP_CALL, mie_pkg::OP_GOTO: begin
        next_two = 1'b1;
      end
      mie_pkg::OP_EXIT_LOAD_W: begin
        next_value   = i_instr.imm;
        next_write_w = 1'b1;
        next_two     = 1'b1;
      end
      mie_pkg::OP_SKIP_BIT_ZERO: begin
        next_skip = !(|(r & bit_mask(i_instr.bit_sel)));
      end
      mie_pkg::OP_SKIP_BIT_ONE: begin
        next_skip = |(r & bit_mask(i_instr.bit_sel));
      end
      mie_pkg::OP_MOVE_SKIP_ZERO, mie_pkg::OP_MOVE_SKIP_NONZERO: begin
        next_write_w = 1'b1;
        next_skip    = is_zero(r) ^
                       (i_instr.op == mie_pkg::OP_MOVE_SKIP_NONZERO);
      end
      mie_pkg::OP_INC_SKIP_ZERO, mie_pkg::OP_DEC_SKIP_ZERO: begin
        next_value = (i_instr.op == mie_pkg::OP_INC_SKIP_ZERO) ? r + 8'h01
                                                              : r - 8'h01;
        next_write_w   = !i_instr.to_reg;
        next_write_mem = i_instr.to_reg;
        next_skip      = is_zero(next_value);
      end
      default: begin
        next_value = r;
      end
    endcase
    // A skip costs the second cycle, spent discarding the next word.
    if (next_skip) begin
      next_two = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ST_EXEC;
      held  <= '0;
    end else begin
      case (state)
        ST_EXEC: begin
          if (take && next_two) begin
            state <= ST_SECOND;
            held  <= i_instr;
          end else if (take && i_instr.op == mie_pkg::OP_SLEEP) begin
            state <= ST_SLEEP;
          end
        end
        ST_SECOND: begin
          state <= ST_EXEC;
        end
        ST_SLEEP: begin
          if (i_wake) begin
            state <= ST_EXEC;
          end
        end
        default: begin
          state <= ST_EXEC;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Working register, flags and lookup byte
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_work_register    <= mie_pkg::W_RST;
      o_flags            <= mie_pkg::FLAGS_RST;
      o_lookup_high_byte <= 8'h00;
    end else if (take) begin
      o_flags <= next_flags;
      if (next_write_w) begin
        o_work_register <= next_value;
      end
    end else if (state == ST_SECOND &&
                 held.op == mie_pkg::OP_LOOKUP_W) begin
      o_lookup_high_byte <= i_flash_rdata[15:8];
      o_work_register    <= i_flash_rdata[7:0];
    end else if (state == ST_SECOND &&
                 held.op == mie_pkg::OP_LOOKUP_REG) begin
      o_lookup_high_byte <= i_flash_rdata[15:8];
    end
  end

  // Timeout and powerdown flags: watchdog kick sets both, sleep clears
  // powerdown; reset sets both.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timeout_flag   <= 1'b1;
      o_powerdown_flag <= 1'b1;
    end else if (take && i_instr.op == mie_pkg::OP_SLEEP) begin
      o_timeout_flag   <= 1'b1;
      o_powerdown_flag <= 1'b0;
    end else if (take && i_instr.op == mie_pkg::OP_WATCHDOG_KICK) begin
      o_timeout_flag   <= 1'b1;
      o_powerdown_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Memory port and handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 8'h00;
      o_mem_wdata <= 8'h00;
      o_flash_re  <= 1'b0;
      o_retire    <= 1'b0;
      o_skip      <= 1'b0;
    end else begin
      o_mem_we   <= 1'b0;
      o_flash_re <= take && (i_instr.op == mie_pkg::OP_LOOKUP_W ||
                             i_instr.op == mie_pkg::OP_LOOKUP_REG);
      o_retire   <= (take && !next_two) || (state == ST_SECOND);
      o_skip     <= take && next_skip;
      if (take && next_write_mem) begin
        o_mem_we    <= 1'b1;
        o_mem_addr  <= i_instr.addr;
        o_mem_wdata <= next_value;
      end else if (state == ST_SECOND &&
                   held.op == mie_pkg::OP_LOOKUP_REG) begin
        o_mem_we    <= 1'b1;
        o_mem_addr  <= held.addr;
        o_mem_wdata <= i_flash_rdata[7:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_ready  <= 1'b1;
      o_asleep <= 1'b0;
    end else begin
      o_ready  <= (state == ST_EXEC && !(take && next_two) &&
                   !(take && i_instr.op == mie_pkg::OP_SLEEP)) ||
                  state == ST_SECOND || (state == ST_SLEEP && i_wake);
      o_asleep <= (state == ST_EXEC && take &&
                   i_instr.op == mie_pkg::OP_SLEEP) ||
                  (state == ST_SLEEP && !i_wake);
    end
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  // flow in second cycle
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_pc       <= mie_pkg::PC_RST;
      sp         <= 3'h0;
      isr_return <= mie_pkg::PC_RST;
    end else if (take && !next_two) begin
      o_pc <= o_pc + 11'h001;
    end else if (state == ST_SECOND) begin
      case (held.op)
        mie_pkg::OP_CALL: begin
          stack[sp] <= o_pc + 11'h001;
          sp        <= sp + 3'h1;
          o_pc      <= held.target;
        end
        mie_pkg::OP_GOTO: begin
          o_pc <= held.target;
        end
        mie_pkg::OP_SUBROUTINE_EXIT, mie_pkg::OP_EXIT_LOAD_W: begin
          sp   <= sp - 3'h1;
          o_pc <= stack[sp - 3'h1];
        end
        mie_pkg::OP_INTERRUPT_EXIT: begin
          o_pc <= isr_return;
        end
        default: begin
          // Skips step over one word; lookups step over themselves.
          o_pc <= (held.op == mie_pkg::OP_LOOKUP_W ||
                   held.op == mie_pkg::OP_LOOKUP_REG) ?
                  o_pc + 11'h001 : o_pc + 11'h002;
        end
      endcase
    end
  end

endmodule : mie_core
`default_nettype wire

// ===== sim/mie_core_chk.sv
// Concurrent checks on the execute unit ports.
`default_nettype none
module mie_core_chk (
  input wire logic                i_clk,
  input wire logic                i_rst_b,
  input wire logic                i_valid,
  input wire mie_pkg::mie_instr_t i_instr,
  input wire logic [7:0]          i_mem_rdata,
  input wire logic                o_ready,
  input wire logic                o_mem_we,
  input wire logic [7:0]          o_mem_wdata,
  input wire logic [7:0]          o_work_register,
  input wire mie_pkg::mie_flags_t o_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [6:0] offer = {i_valid && o_ready, i_instr.op};
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Only a ready core takes work, so blocked cycles never start a check.
  function automatic logic took(input logic [6:0] t, logic [5:0] o);
    return t[6] && t[5:0] == o;
  endfunction : took
  property p_store;
    took(offer, mie_pkg::OP_STORE_W) |=> o_mem_we &&
      o_mem_wdata == $past(o_work_register) && $stable(o_flags);
  endproperty
  a_store: assert property (p_store) else $error("store bad");
  property p_move;
    took(offer, mie_pkg::OP_MOVE) |=>
      o_work_register == $past(i_mem_rdata) &&
      o_flags.zero == (o_work_register == 8'h00);
  endproperty
  a_move: assert property (p_move) else $error("move bad");
  property p_ximm;
    took(offer, mie_pkg::OP_XOR_IMM) |=> o_work_register ==
      ($past(o_work_register) ^ $past(i_instr.imm));
  endproperty
  a_ximm: assert property (p_ximm) else $error("xor bad");
  property p_rrc;
    took(offer, mie_pkg::OP_ROT_RIGHT_CARRY) && !i_instr.to_reg |=>
      o_work_register[7] == $past(o_flags.carry) &&
      o_flags.carry == $past(i_mem_rdata[0]);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rrc bad");
  property p_rlc;
    took(offer, mie_pkg::OP_ROT_LEFT_CARRY) |=>
      o_flags.carry == $past(i_mem_rdata[7]);
  endproperty
  a_rlc: assert property (p_rlc) else $error("rlc bad");
  property p_inc;
    took(offer, mie_pkg::OP_INCREMENT) && !i_instr.to_reg |=>
      o_work_register == $past(i_mem_rdata) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("inc bad");
  property p_sum;
    took(offer, mie_pkg::OP_SUM) && !i_instr.to_reg |=>
      {o_flags.carry, o_work_register} ==
      {1'h0, $past(o_work_register)} + {1'h0, $past(i_mem_rdata)};
  endproperty
  a_sum: assert property (p_sum) else $error("sum bad");
  property p_bit;
    took(offer, mie_pkg::OP_BIT_ONE) |=> o_mem_we && o_mem_wdata ==
      ($past(i_mem_rdata) | (8'h01 << $past(i_instr.bit_sel)));
  endproperty
  a_bit: assert property (p_bit) else $error("bit set bad");
  c_sum: cover property (took(offer, mie_pkg::OP_SUM));
  c_look: cover property (took(offer, mie_pkg::OP_LOOKUP_REG) ##2 o_mem_we);
  c_bit: cover property (took(offer, mie_pkg::OP_BIT_ONE));
endmodule : mie_core_chk
bind mie_core mie_core_chk mie_core_chk_inst (.i_clk, .i_rst_b, .i_valid,
  .i_instr, .i_mem_rdata, .o_ready, .o_mem_we, .o_mem_wdata,
  .o_work_register, .o_flags);
`default_nettype wire

// ===== sim/mie_mem_model.sv
// Data memory and program flash word facing the execute unit.
`default_nettype none
module mie_mem_model #(
  parameter logic [15:0] WORD = 16'hA55A
) (
  input  wire logic        i_clk,
  input  wire logic        i_we,
  input  wire logic [7:0]  i_waddr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic [7:0]  i_raddr,
  input  wire logic        i_flash_re,
  output logic      [7:0]  o_rdata,
  output logic      [15:0] o_flash
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [256];
  assign o_rdata = mem[i_raddr];
  // Outside the read cycle the word is inverted, so a late sample shows.
  assign o_flash = i_flash_re ? WORD : ~WORD;
  always_ff @(posedge i_clk) begin
    if (i_we) mem[i_waddr] <= i_wdata;
  end
endmodule : mie_mem_model
`default_nettype wire

// ===== sim/test_mie_core.sv
// Self-checking bench for the execute unit.
`default_nettype none
module test_mie_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'h0;
  logic i_rst_b = 1'h0;
  logic i_valid = 1'h0;
  logic skp, ready, skip, we, fre, slp;
  logic wake = 1'h0;
  logic [1:0] tp;
  logic [7:0] rdata, waddr, wdata, w, lkh;
  logic [15:0] flash;
  logic [10:0] pc;
  mie_pkg::mie_flags_t flags;
  int error_cnt = 0;
  int total_checks = 0;
  mie_pkg::mie_instr_t instr =
    '{mie_pkg::OP_IDLE, 1'h0, 8'h10, 8'h00, 3'h3, 11'h123};
  mie_core mie_core_inst (.i_clk, .i_rst_b, .i_valid, .i_instr(instr),
    .i_mem_rdata(rdata), .i_flash_rdata(flash), .i_wake(wake),
    .o_ready(ready), .o_retire(), .o_skip(skip), .o_mem_we(we),
    .o_mem_addr(waddr), .o_mem_wdata(wdata), .o_flash_re(fre),
    .o_work_register(w), .o_lookup_high_byte(lkh), .o_flags(flags),
    .o_timeout_flag(tp[1]), .o_powerdown_flag(tp[0]), .o_pc(pc),
    .o_asleep(slp));
  mie_mem_model mie_mem_model_inst (.i_clk, .i_we(we), .i_waddr(waddr),
    .i_wdata(wdata), .i_raddr(instr.addr), .i_flash_re(fre),
    .o_rdata(rdata), .o_flash(flash));
  always #25 i_clk = ~i_clk;
  task automatic test_done();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [7:0] g, e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Spacing of three idle cycles keeps clear of any two-cycle blocking.
  task automatic op1(input mie_pkg::mie_op_t op, input logic t,
                     logic [7:0] v7);
    instr.op <= op;
    instr.to_reg <= t;
    instr.imm <= v7;
    i_valid <= 1'h1;
    @(posedge i_clk);
    i_valid <= 1'h0;
    skp = 1'h0;
    repeat (3) begin
      @(posedge i_clk);
      skp = skp | skip;
    end
  endtask : op1
  task automatic run(input mie_pkg::mie_op_t op, input logic [1:0] tc,
                     input logic [7:0] v, d, r, sf);
    op1(mie_pkg::OP_LOAD_IMMEDIATE, 1'h0, d);
    op1(mie_pkg::OP_STORE_W, 1'h1, d);
    op1(mie_pkg::OP_LOAD_IMMEDIATE, 1'h0, 8'hFF);
    op1(mie_pkg::OP_SUM_IMM, 1'h0, {7'h00, tc[0]});
    op1(mie_pkg::OP_LOAD_IMMEDIATE, 1'h0, v);
    op1(op, tc[1], d);
    chk({3'h0, skp, flags}, sf);
    chk(tc[1] ? mie_mem_model_inst.mem[8'h10] : w, r);
  endtask : run
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'h1;
    @(posedge i_clk);
    run(mie_pkg::OP_MOVE, 2'h0, 8'h5A, 8'h00, 8'h00, 8'h02);
    run(mie_pkg::OP_STORE_W, 2'h3, 8'h3C, 8'h11, 8'h3C, 8'h0E);
    run(mie_pkg::OP_ZERO_PROBE, 2'h2, 8'h00, 8'h00, 8'h00, 8'h02);
    run(mie_pkg::OP_OR, 2'h2, 8'h30, 8'h0A, 8'h3A, 8'h00);
    run(mie_pkg::OP_AND, 2'h1, 8'h77, 8'h0F, 8'h07, 8'h0C);
    run(mie_pkg::OP_XOR_IMM, 2'h0, 8'h55, 8'h55, 8'h00, 8'h02);
    run(mie_pkg::OP_NIBBLE_EXCHANGE, 2'h1, 8'h00, 8'h35, 8'h53, 8'h0E);
    run(mie_pkg::OP_INVERT, 2'h2, 8'h00, 8'h0A, 8'hF5, 8'h00);
    run(mie_pkg::OP_ROT_RIGHT_CARRY, 2'h1, 8'h00, 8'h03, 8'h81, 8'h0E);
    run(mie_pkg::OP_ROT_LEFT_CARRY, 2'h2, 8'h00, 8'h83, 8'h06, 8'h08);
    run(mie_pkg::OP_ROT_LEFT, 2'h0, 8'h00, 8'h81, 8'h03, 8'h00);
    run(mie_pkg::OP_ROT_RIGHT, 2'h3, 8'h00, 8'h03, 8'h81, 8'h0E);
    run(mie_pkg::OP_INCREMENT, 2'h0, 8'h00, 8'hFF, 8'h00, 8'h02);
    run(mie_pkg::OP_DECREMENT, 2'h3, 8'h00, 8'h00, 8'hFF, 8'h0C);
    run(mie_pkg::OP_BIT_ONE, 2'h3, 8'h00, 8'h00, 8'h08, 8'h0E);
    run(mie_pkg::OP_SUM, 2'h0, 8'h09, 8'h77, 8'h80, 8'h05);
    run(mie_pkg::OP_SUM_CARRY, 2'h3, 8'h09, 8'h77, 8'h81, 8'h05);
    run(mie_pkg::OP_FWD_DIFF, 2'h0, 8'h77, 8'h80, 8'h09, 8'h09);
    run(mie_pkg::OP_REV_DIFF_BORROW, 2'h3, 8'h80, 8'h77, 8'h08, 8'h09);
    run(mie_pkg::OP_LOOKUP_REG, 2'h2, 8'h00, 8'h00, 8'h5A, 8'h00);
    chk(lkh, 8'hA5);
    run(mie_pkg::OP_SKIP_BIT_ZERO, 2'h0, 8'h11, 8'h00, 8'h11, 8'h10);
    run(mie_pkg::OP_MOVE_SKIP_ZERO, 2'h0, 8'h11, 8'h00, 8'h00, 8'h10);
    run(mie_pkg::OP_INC_SKIP_ZERO, 2'h2, 8'h00, 8'hFF, 8'h00, 8'h10);
    run(mie_pkg::OP_EXIT_LOAD_W, 2'h1, 8'h11, 8'h3C, 8'h3C, 8'h0E);
    run(mie_pkg::OP_GOTO, 2'h0, 8'h11, 8'h00, 8'h11, 8'h00);
    chk(pc[7:0], 8'h23);
    op1(mie_pkg::OP_SLEEP, 1'h0, 8'h00);
    chk({5'h00, slp, tp}, 8'h06);
    wake <= 1'h1;
    @(posedge i_clk);
    op1(mie_pkg::OP_WATCHDOG_KICK, 1'h0, 8'h00);
    chk({5'h00, slp, tp}, 8'h03);
    test_done();
  end
endmodule : test_mie_core
`default_nettype wire
